/* File: hdl/cbl_regs.svh */
// Constants for the carry bit logic and branch condition slice
`ifndef CBL_REGS_SVH
`define CBL_REGS_SVH
`define CBL_BYTE_W 8
`define CBL_BITNO_W 3
`define CBL_OP_W 4
`define CBL_COND_W 3
`define CBL_CARRY_RST 1'h0
`define CBL_PC_W 16
`endif

/* File: hdl/cbl_pkg.sv */
// Types for the carry bit logic and branch condition slice
`include "cbl_regs.svh"
package cbl_pkg;
  typedef enum logic [3:0] {
    CBL_NOP = 4'h0,
    CBL_OR_BIT = 4'h1,
    CBL_OR_INV = 4'h2,
    CBL_XOR_BIT = 4'h3,
    CBL_XOR_INV = 4'h4,
    CBL_LOAD_BIT = 4'h5,
    CBL_LOAD_INV = 4'h6,
    CBL_STORE_BIT = 4'h7,
    CBL_STORE_INV = 4'h8
  } cbl_op_t;
  typedef enum logic [2:0] {
    CBL_BR_ALWAYS = 3'h0,
    CBL_BR_NEVER = 3'h1,
    CBL_BR_HIGHER = 3'h2,
    CBL_BR_HIGHER_SAME = 3'h3
  } cbl_cond_t;
endpackage

/* File: hdl/cbl_branch_eval.sv */
// Branch condition evaluator for the always, never, higher and higher-or-same forms
`timescale 1ns/1ps
module cbl_branch_eval
  import cbl_pkg::*;
(
  input wire logic [2:0] cond_i,
  input wire logic carry_i,
  input wire logic zero_i,
  output logic taken_o
);
  // Unknown codes are never taken, safest choice for a slice
  always_comb begin
    case (cond_i)
      CBL_BR_ALWAYS: taken_o = 1'b1;
      CBL_BR_NEVER: taken_o = 1'b0;
      CBL_BR_HIGHER: taken_o = ~(carry_i | zero_i);
      CBL_BR_HIGHER_SAME: taken_o = ~carry_i;
      default: taken_o = 1'b0;
    endcase
  end
endmodule // cbl_branch_eval

/* File: hdl/cbl_carry_bit_logic.sv */
// Carry flag bit operations and branch decision for the core datapath
`timescale 1ns/1ps
`include "cbl_regs.svh"
// Notes on behaviour
// - OR selected bit into carry
// - OR inverted selected bit into carry
// - XOR selected bit into carry
// - XOR inverted selected bit into carry
// - Load selected bit into carry
// - Load inverted selected bit into carry
// - Store carry into selected bit
// - Store inverted carry into selected bit
// - Bit number from 3-bit immediate only
// - Branch always, never, high when C|Z zero
// - Higher-or-same branch taken when carry zero
module cbl_carry_bit_logic
  import cbl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic op_valid_i,
  input wire logic [3:0] op_i,
  input wire logic [2:0] bit_no_i,
  input wire logic [7:0] operand_i,
  input wire logic br_valid_i,
  input wire logic [2:0] cond_i,
  input wire logic zero_i,
  input wire logic carry_load_i,
  input wire logic carry_value_i,
  output logic carry_o,
  output logic [7:0] result_o,
  output logic result_we_o,
  output logic br_taken_o,
  output logic br_done_o
);
  // All state in one record: carry flag, store byte and branch decision.
  // Strobes live in the record too, so every output leaves a flip-flop.
  typedef struct packed {
    logic carry;
    logic [`CBL_BYTE_W-1:0] result;
    logic result_we;
    logic br_taken;
    logic br_done;
  } cbl_state_t;

  cbl_state_t st_q, st_d;
  logic sel_bit;
  logic taken;

  // Picks one bit of the byte by the immediate index.
  // Only the 3-bit immediate reaches here; no register-held index exists.
  function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] n);
    return b[n];
  endfunction

  // Replaces one bit, rest of the byte stays as read
  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] n,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[n] = v;
    return r;
  endfunction

  assign sel_bit = pick_bit(operand_i, bit_no_i);

  cbl_branch_eval u_br (
    .cond_i(cond_i),
    .carry_i(st_q.carry),
    .zero_i(zero_i),
    .taken_o(taken)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: carry update, store result, branch decision.
  // A direct flag write is applied first so that an OR, XOR or load bit operation
  // in the same cycle overrides it; the core never expects both to land.
  always_comb begin
    st_d = st_q;
    st_d.result_we = 1'b0;
    st_d.br_done = 1'b0;
    if (carry_load_i) begin
      st_d.carry = carry_value_i; // Flag write from rest of core
    end
    if (op_valid_i) begin
      case (op_i)
        CBL_OR_BIT: st_d.carry = st_q.carry | sel_bit;
        CBL_OR_INV: st_d.carry = st_q.carry | ~sel_bit;
        CBL_XOR_BIT: st_d.carry = st_q.carry ^ sel_bit;
        CBL_XOR_INV: st_d.carry = st_q.carry ^ ~sel_bit;
        CBL_LOAD_BIT: st_d.carry = sel_bit;
        CBL_LOAD_INV: st_d.carry = ~sel_bit;
        CBL_STORE_BIT: begin
          st_d.result = put_bit(operand_i, bit_no_i, st_q.carry);
          st_d.result_we = 1'b1;
        end
        CBL_STORE_INV: begin
          st_d.result = put_bit(operand_i, bit_no_i, ~st_q.carry);
          st_d.result_we = 1'b1;
        end
        default: st_d.result_we = 1'b0;
      endcase
    end
    // Branches look at the carry before this cycle's update
    if (br_valid_i) begin
      st_d.br_taken = taken;
      st_d.br_done = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= '{carry: `CBL_CARRY_RST, result: '0, result_we: 1'b0,
                br_taken: 1'b0, br_done: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign carry_o = st_q.carry;
  assign result_o = st_q.result;
  assign result_we_o = st_q.result_we;
  assign br_taken_o = st_q.br_taken;
  assign br_done_o = st_q.br_done;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  or_bit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && !carry_load_i && op_i == CBL_OR_BIT |=> carry_o == ($past(carry_o) | $past(sel_bit)))
    else $error("or bit wrong");
  or_inv_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && !carry_load_i && op_i == CBL_OR_INV |=> carry_o == ($past(carry_o) | !$past(sel_bit)))
    else $error("or inverted bit wrong");
  xor_bit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && !carry_load_i && op_i == CBL_XOR_BIT |=> carry_o == ($past(carry_o) ^ $past(sel_bit)))
    else $error("xor bit wrong");
  xor_inv_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && !carry_load_i && op_i == CBL_XOR_INV |=> carry_o == ($past(carry_o) ^ !$past(sel_bit)))
    else $error("xor inverted bit wrong");
  load_bit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && op_i == CBL_LOAD_BIT |=> carry_o == $past(operand_i[bit_no_i]))
    else $error("load bit wrong");
  load_inv_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && op_i == CBL_LOAD_INV |=> carry_o != $past(operand_i[bit_no_i]))
    else $error("load inverted bit wrong");
  store_bit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && op_i == CBL_STORE_BIT |=> result_we_o && result_o[$past(bit_no_i)] == $past(carry_o))
    else $error("store bit wrong");
  store_inv_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && op_i == CBL_STORE_INV |=> result_we_o && result_o[$past(bit_no_i)] != $past(carry_o))
    else $error("store inverted bit wrong");
  store_keep_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && (op_i == CBL_STORE_BIT || op_i == CBL_STORE_INV) |=>
      ((result_o ^ $past(operand_i)) & ~(8'h01 << $past(bit_no_i))) == 8'h00)
    else $error("store touched other bits");
  br_high_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    br_valid_i && cond_i == CBL_BR_HIGHER |=> br_done_o && br_taken_o == !($past(carry_o) || $past(zero_i)))
    else $error("high branch wrong");
  br_fixed_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    br_valid_i && (cond_i == CBL_BR_ALWAYS || cond_i == CBL_BR_NEVER) |=>
      br_taken_o == ($past(cond_i) == CBL_BR_ALWAYS))
    else $error("always or never branch wrong");
  br_hs_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    br_valid_i && cond_i == CBL_BR_HIGHER_SAME |=> br_taken_o == !$past(carry_o))
    else $error("higher or same branch wrong");
  cv_store_c: cover property (@(posedge ref_clk_i) op_valid_i && op_i == CBL_STORE_BIT);
  cv_xor_c: cover property (@(posedge ref_clk_i) op_valid_i && op_i == CBL_XOR_INV);
  cv_br_c: cover property (@(posedge ref_clk_i) br_valid_i && cond_i == CBL_BR_HIGHER && taken);
  cv_load_c: cover property (@(posedge ref_clk_i) op_valid_i && op_i == CBL_LOAD_INV);
  cv_hs_c: cover property (@(posedge ref_clk_i) br_valid_i && cond_i == CBL_BR_HIGHER_SAME);

  ////////////////////////////////////////////////////////////////////////////
  // Hold, pulse and reset checks
  // Strobes must be single-cycle, or the core would write a byte twice
  reset_vals_a: assert property (@(posedge ref_clk_i)
    reset_i |=> carry_o == 1'b0 && result_o == 8'h00 && !result_we_o && !br_done_o && !br_taken_o)
    else $error("reset values wrong");
  nop_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_valid_i && !carry_load_i && (op_i == CBL_NOP || op_i > CBL_STORE_INV) |=>
      $stable(carry_o) && !result_we_o)
    else $error("unknown op changed state");
  carry_load_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    carry_load_i && !op_valid_i |=> carry_o == $past(carry_value_i))
    else $error("direct carry write lost");
  cond_unknown_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    br_valid_i && cond_i > CBL_BR_HIGHER_SAME |=> br_done_o && !br_taken_o)
    else $error("unknown condition taken");
  we_pulse_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !op_valid_i |=> !result_we_o)
    else $error("write strobe without store");
  done_pulse_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !br_valid_i |=> !br_done_o)
    else $error("branch done without request");
  result_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !(op_valid_i && (op_i == CBL_STORE_BIT || op_i == CBL_STORE_INV)) |=> $stable(result_o))
    else $error("result byte moved");
  taken_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !br_valid_i |=> $stable(br_taken_o))
    else $error("branch decision moved");
endmodule // cbl_carry_bit_logic

/* File: verification/carry_bit_logic_and_branch_condition_bench.sv */
// Self-checking bench for the carry bit operations and branch decision
`timescale 1ns/1ps
module carry_bit_logic_and_branch_condition_bench;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic op_valid_i = 1'b0;
  logic [3:0] op_i = 4'h0;
  logic [2:0] bit_no_i = 3'h0;
  logic [7:0] operand_i = 8'h00;
  logic br_valid_i = 1'b0;
  logic [2:0] cond_i = 3'h0;
  logic zero_i = 1'b0;
  logic carry_load_i = 1'b0;
  logic carry_value_i = 1'b0;
  logic carry_o, result_we_o, br_taken_o, br_done_o;
  logic [7:0] result_o;
  int fails = 0;
  int comparisons = 0;
  cbl_carry_bit_logic u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .bit_no_i(bit_no_i), .operand_i(operand_i), .br_valid_i(br_valid_i),
    .cond_i(cond_i), .zero_i(zero_i), .carry_load_i(carry_load_i),
    .carry_value_i(carry_value_i), .carry_o(carry_o), .result_o(result_o),
    .result_we_o(result_we_o), .br_taken_o(br_taken_o), .br_done_o(br_done_o));
  // 125 MHz clock
  always #4 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers; inputs move only by non-blocking assignment at the edge
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic set_carry(input logic v);
    @(posedge ref_clk_i);
    carry_load_i <= 1'b1;
    carry_value_i <= v;
    @(posedge ref_clk_i);
    carry_load_i <= 1'b0;
    #1;
  endtask
  // Outputs are sampled 1 ns after the taking edge so its updates have landed
  task automatic run_op(input logic [3:0] op, input logic [2:0] b, input logic [7:0] d);
    @(posedge ref_clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    bit_no_i <= b;
    operand_i <= d;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Every carry-updating op, every bit number, both carry values
  task automatic test_carry_ops;
    logic s;
    logic e;
    for (int c = 0; c < 2; c++) begin
      for (int op = 1; op < 7; op++) begin
        for (int b = 0; b < 8; b++) begin
          set_carry(c[0]);
          s = 8'h3C >> b;
          case (op)
            1: e = c[0] | s;
            2: e = c[0] | ~s;
            3: e = c[0] ^ s;
            4: e = c[0] ^ ~s;
            5: e = s;
            default: e = ~s;
          endcase
          run_op(op[3:0], b[2:0], 8'h3C);
          check({7'h00, carry_o}, {7'h00, e});
        end
      end
    end
    $display("test carry_ops done");
  endtask
  // Stores keep the other seven bits and strobe the write for one cycle
  task automatic test_store;
    logic [7:0] e;
    for (int c = 0; c < 2; c++) begin
      for (int op = 7; op < 9; op++) begin
        for (int b = 0; b < 8; b++) begin
          set_carry(c[0]);
          e = (8'h5A & ~(8'h01 << b)) | ({7'h00, c[0] ^ (op == 8)} << b);
          run_op(op[3:0], b[2:0], 8'h5A);
          check(result_o, e);
          check({7'h00, result_we_o}, 8'h01);
          @(posedge ref_clk_i);
          #1;
          check({7'h00, result_we_o}, 8'h00);
        end
      end
    end
    $display("test store done");
  endtask
  // Always, never, higher, higher-or-same and one unused code
  task automatic test_branch;
    logic e;
    for (int k = 0; k < 20; k++) begin
      set_carry(k[0]);
      @(posedge ref_clk_i);
      br_valid_i <= 1'b1;
      cond_i <= (k / 4 == 4) ? 3'h5 : 3'(k / 4);
      zero_i <= k[1];
      @(posedge ref_clk_i);
      br_valid_i <= 1'b0;
      #1;
      case (k / 4)
        0: e = 1'b1;
        2: e = ~(k[0] | k[1]);
        3: e = ~k[0];
        default: e = 1'b0;
      endcase
      check({6'h00, br_done_o, br_taken_o}, {6'h00, 1'b1, e});
    end
    $display("test branch done");
  endtask
  // Unused op codes hold the carry; a mid-run reset clears every output
  task automatic test_hold_reset;
    set_carry(1'b1);
    run_op(4'h0, 3'h0, 8'h00);
    check({7'h00, carry_o}, 8'h01);
    run_op(4'hF, 3'h7, 8'h00);
    check({7'h00, carry_o}, 8'h01);
    @(posedge ref_clk_i);
    br_valid_i <= 1'b1;
    cond_i <= 3'h0;
    @(posedge ref_clk_i);
    br_valid_i <= 1'b0;
    #1;
    check({7'h00, br_taken_o}, 8'h01);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #1;
    check({4'h0, br_taken_o, br_done_o, result_we_o, carry_o}, 8'h00);
    check(result_o, 8'h00);
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    set_carry(1'b1);
    check({7'h00, carry_o}, 8'h01);
    $display("test hold_reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Tests need about 650 cycles; the watchdog allows far more
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    test_carry_ops();
    test_store();
    test_branch();
    test_hold_reset();
    report_and_stop();
  end
endmodule // carry_bit_logic_and_branch_condition_bench
